// ==== shared/ofm_pkg.sv ====
`default_nettype none
package ofm_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TX_OVH = 8'h04;
  localparam logic [7:0] OFF_RX_OVH = 8'h08;
  localparam int RXS_LOCKED = 8;
  localparam int RXS_LOST = 9;
  localparam int RXS_CONTACT = 10;

  // ****************************************
  // modes and lock states
  // ****************************************
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_STD = 2'h1,
    MODE_ENH = 2'h3,
    MODE_CUST = 2'h2
  } ofm_mode_t;

  typedef enum logic [1:0] {
    LK_HUNT = 2'h0,
    LK_VERIFY = 2'h1,
    LK_LOCKED = 2'h3,
    LK_SPARE = 2'h2
  } ofm_lock_t;

  // control word: bits [1:0] tx mode, [3:2] rx mode, [4] single-ended, [5] scrambler,
  // [13:6] tx data bytes per framing byte, [21:14] rx data bytes per framing byte
  typedef struct packed {
    logic [7:0] rx_load;
    logic [7:0] tx_load;
    logic scram_en;
    logic iface_se;
    ofm_mode_t rx_mode;
    ofm_mode_t tx_mode;
  } ofm_ctrl_t;

  // overhead word: [0] backward alarm, [1] multiframe bit, [7:2] control channel
  typedef struct packed {
    logic [5:0] ucc;
    logic mframe;
    logic bwd_alarm;
  } ofm_ovh_t;

  localparam logic [21:0] CTRL_RST = 22'h000000;
  localparam logic [7:0] OVH_RST = 8'h00;

  // ****************************************
  // frame layout
  // ****************************************
  localparam logic [6:0] FAW = 7'h1B;
  localparam logic BIT32_ALIGN = 1'b1;
  localparam logic [7:0] LOAD_FIXED = 8'h0F;
  localparam logic [7:0] LOAD_MIN = 8'h01;
  localparam logic [7:0] SOC_IDLE = 8'hFF;
  localparam logic [1:0] FB_ALIGN = 2'h0;
  localparam logic [1:0] FB_SIG_A = 2'h1;
  localparam logic [1:0] FB_HOUSE = 2'h2;
  localparam logic [1:0] FB_SIG_B = 2'h3;
  // frame bit n sits at byte index 8-n, bit 1 first on the wire
  localparam int B1 = 7;
  localparam int B2 = 6;
  localparam int B3 = 5;
  localparam int B4 = 4;
  localparam int B5 = 3;
  localparam int B6 = 2;
  localparam int B7 = 1;
  localparam int B8 = 0;
  localparam logic [1:0] MISS_LIMIT = 2'h2;
  localparam logic [14:0] LFSR_SEED = 15'h7FFF;

endpackage
`default_nettype wire

// ==== rtl/ofm_framer.sv ====
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE_01: framing bytes make aggregate 16/15 of data
// RULE_02: three selectable modes, standard enhanced custom
// RULE_03: service channel always; control channel enhanced/custom
// RULE_04: channel bits only inside framing bytes
// RULE_05: standard mode leaves bytes 16, 48 empty
// RULE_06: standard: byte 32 bit 1 carries service bit
// RULE_07: byte 32 bit 2 is alignment pattern
// RULE_08: byte 32 bit 3 carries backward alarm
// RULE_09: byte 32 bit 4 carries multiframe bit
// RULE_10: standard: byte 32 bits 5-8 unused
// RULE_11: standard: through data is 15/16 aggregate
// RULE_12: standard: service channel raw, unbuffered
// RULE_13: single-ended standard: output service channel clocks
// RULE_14: differential interface: no service channel clocks
// RULE_15: enhanced: bytes 16, 48 carry service channel
// RULE_16: enhanced: control uses byte1 bit1, byte32 bits
// RULE_17: enhanced/custom: service channel is buffered
// RULE_18: far end must use matching mode
// RULE_19: transmit and receive configured separately
// RULE_20: custom: two remote contact channels to relays
// RULE_21: frame-synchronous scrambler on data bytes
// RULE_22: custom: 4 to 1020 data bytes per frame
// RULE_23: fixed modes: 64-byte frame, 4 framing bytes
// RULE_24: receiver locks on pattern, flags loss
module ofm_framer
(
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // terrestrial transmit data
  input wire logic [7:0] TD_TX_BYTE,
  input wire logic TD_TX_VALID,
  output logic TD_TX_TAKE,
  // aggregate transmit toward modulator
  input wire logic AGG_TX_REQ,
  output logic [7:0] AGG_TX_BYTE,
  output logic AGG_TX_VALID,
  // aggregate receive from demodulator
  input wire logic [7:0] AGG_RX_BYTE,
  input wire logic AGG_RX_VALID,
  // terrestrial receive data
  output logic [7:0] TD_RX_BYTE,
  output logic TD_RX_VALID,
  // service overhead channel
  input wire logic [7:0] SOC_TX_BYTE,
  input wire logic SOC_TX_VALID,
  output logic SOC_TX_READY,
  input wire logic SOC_TX_BIT,
  output logic SOC_TX_CLK,
  output logic [7:0] SOC_RX_BYTE,
  output logic SOC_RX_VALID,
  output logic SOC_RX_BIT,
  output logic SOC_RX_CLK,
  // remote contact channels
  input wire logic [1:0] CONTACT_IN,
  output logic [1:0] RELAY_OUT,
  // lock status
  output logic LOCKED,
  output logic LOCK_LOST
);
  import ofm_pkg::*;

  // ****************************************
  // register file and bus slave
  // ****************************************
  ofm_ctrl_t ctrl;
  ofm_ovh_t tx_ovh;
  ofm_ovh_t rx_ovh;
  logic lost_sticky;
  logic ap_sel;
  logic ap_write;
  logic [7:0] ap_addr;
  logic [31:0] rd_word;
  logic addr_take;

  assign addr_take = HSEL && HTRANS[1] && HREADY;

  // read mux, bits above each field read as zero
  always_comb
  begin
    rd_word = 32'h00000000;
    case (HADDR[7:0])
      OFF_CTRL: rd_word[21:0] = ctrl;
      OFF_TX_OVH: rd_word[7:0] = tx_ovh;
      OFF_RX_OVH:
      begin
        rd_word[7:0] = rx_ovh;
        rd_word[RXS_LOCKED] = LOCKED;
        rd_word[RXS_LOST] = lost_sticky;
        rd_word[RXS_CONTACT+1:RXS_CONTACT] = RELAY_OUT;
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  // address phase capture; zero wait, always okay
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ap_sel <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
    else if (CLK_EN)
    begin
      ap_sel <= addr_take;
      ap_write <= HWRITE;
      ap_addr <= HADDR[7:0];
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (addr_take && !HWRITE)
        HRDATA <= rd_word;
    end
  end

  // data phase writes; mode registers steer both directions independently
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ctrl <= CTRL_RST;
      tx_ovh <= OVH_RST;
    end
    else if (CLK_EN && ap_sel && ap_write)
    begin
      if (ap_addr == OFF_CTRL)
        ctrl <= HWDATA[21:0]; // see RULE_02 see RULE_19
      if (ap_addr == OFF_TX_OVH)
        tx_ovh <= HWDATA[7:0];
    end
  end

  // loss-of-lock sticky: a new loss beats a same-cycle write-one clear
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      lost_sticky <= 1'b0;
    else if (CLK_EN)
    begin
      if (LOCK_LOST)
        lost_sticky <= 1'b1;
      else if (ap_sel && ap_write && ap_addr == OFF_RX_OVH && HWDATA[RXS_LOST])
        lost_sticky <= 1'b0;
    end
  end

  // ****************************************
  // transmit framer
  // ****************************************
  logic [1:0] tx_fb;
  logic [7:0] tx_dcnt;
  logic [7:0] tx_load;
  logic tx_fr;
  logic tx_ext;
  logic [14:0] tx_lfsr;
  logic [7:0] next_fr_byte;
  logic [7:0] td_scr;
  logic soc_full;
  logic [7:0] soc_hold;
  logic next_soc_full;
  logic soc_use;
  logic [1:0] ct_s1;
  logic [1:0] ct_s2;

  assign tx_ext = (ctrl.tx_mode == MODE_ENH) || (ctrl.tx_mode == MODE_CUST); // see RULE_03
  // fixed modes: 15 data bytes per framing byte, 64-byte frame
  assign tx_load = (ctrl.tx_mode == MODE_CUST) ?
    ((ctrl.tx_load < LOAD_MIN) ? LOAD_MIN : ctrl.tx_load) : LOAD_FIXED; // see RULE_22 see RULE_23
  assign tx_fr = (ctrl.tx_mode != MODE_OFF) && (tx_dcnt == 8'h00); // see RULE_01 see RULE_11
  // scrambler runs only while framed, so both ends restart it together
  assign td_scr = (TD_TX_VALID ? TD_TX_BYTE : 8'h00) ^
    ((ctrl.scram_en && ctrl.tx_mode != MODE_OFF) ? tx_lfsr[7:0] : 8'h00);
  assign soc_use = AGG_TX_REQ && tx_fr && tx_ext && soc_full &&
    (tx_fb == FB_SIG_A || tx_fb == FB_SIG_B);
  assign next_soc_full = (SOC_TX_VALID && SOC_TX_READY) || (soc_full && !soc_use);

  // framing byte contents per position in the frame
  always_comb
  begin
    next_fr_byte = 8'h00;
    case (tx_fb)
      FB_ALIGN:
      begin
        next_fr_byte[6:0] = FAW;
        next_fr_byte[B1] = tx_ext ? tx_ovh.ucc[0] : 1'b0; // see RULE_16
      end
      FB_SIG_A, FB_SIG_B:
        // standard leaves these empty; extended modes carry the service byte
        next_fr_byte = tx_ext ? (soc_full ? soc_hold : SOC_IDLE) : 8'h00; // see RULE_05 see RULE_15
      FB_HOUSE:
      begin
        next_fr_byte[B1] = tx_ext ? tx_ovh.ucc[1] : SOC_TX_BIT; // see RULE_06 see RULE_16
        next_fr_byte[B2] = BIT32_ALIGN; // see RULE_07
        next_fr_byte[B3] = tx_ovh.bwd_alarm; // see RULE_08
        next_fr_byte[B4] = tx_ovh.mframe; // see RULE_09
        // standard mode leaves bits 5 to 8 at zero
        if (tx_ext) // see RULE_10
        begin
          next_fr_byte[B5] = tx_ovh.ucc[2]; // see RULE_16
          next_fr_byte[B6] = tx_ovh.ucc[3];
          next_fr_byte[B7] = (ctrl.tx_mode == MODE_CUST) ? ct_s2[0] : tx_ovh.ucc[4]; // see RULE_20
          next_fr_byte[B8] = (ctrl.tx_mode == MODE_CUST) ? ct_s2[1] : tx_ovh.ucc[5];
        end
      end
      default: next_fr_byte = 8'h00;
    endcase
  end

  // byte position counters: slot 0 framing, then tx_load data bytes
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tx_fb <= FB_ALIGN;
      tx_dcnt <= 8'h00;
    end
    else if (CLK_EN && AGG_TX_REQ)
    begin
      if (ctrl.tx_mode == MODE_OFF)
      begin
        // park on the alignment slot so framing restarts with a frame start
        tx_fb <= FB_ALIGN;
        tx_dcnt <= 8'h00;
      end
      else if (tx_dcnt >= tx_load)
      begin
        tx_dcnt <= 8'h00;
        tx_fb <= tx_fb + 2'h1;
      end
      else
        tx_dcnt <= tx_dcnt + 8'h01;
    end
  end

  // frame-synchronous scrambler, reseeded at every frame start
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      tx_lfsr <= LFSR_SEED;
    else if (CLK_EN && AGG_TX_REQ)
    begin
      if (tx_fr && tx_fb == FB_ALIGN)
        tx_lfsr <= LFSR_SEED; // see RULE_21
      else if (!tx_fr)
        tx_lfsr <= {tx_lfsr[13:0], tx_lfsr[14] ^ tx_lfsr[13]};
    end
  end

  // aggregate output and data take strobe
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      AGG_TX_BYTE <= 8'h00;
      AGG_TX_VALID <= 1'b0;
      TD_TX_TAKE <= 1'b0;
      SOC_TX_CLK <= 1'b0;
    end
    else if (CLK_EN)
    begin
      AGG_TX_VALID <= AGG_TX_REQ;
      TD_TX_TAKE <= AGG_TX_REQ && !tx_fr && TD_TX_VALID; // see RULE_04
      // raw standard-mode clock only on the single-ended interface
      SOC_TX_CLK <= AGG_TX_REQ && tx_fr && tx_fb == FB_HOUSE &&
        ctrl.tx_mode == MODE_STD && ctrl.iface_se; // see RULE_12 see RULE_13 see RULE_14
      if (AGG_TX_REQ)
        AGG_TX_BYTE <= tx_fr ? next_fr_byte : td_scr;
    end
  end

  // one-byte service holding stage decouples port rate from frame rate
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      soc_full <= 1'b0;
      soc_hold <= 8'h00;
      SOC_TX_READY <= 1'b0;
    end
    else if (CLK_EN)
    begin
      soc_full <= next_soc_full; // see RULE_17
      SOC_TX_READY <= !next_soc_full && tx_ext;
      if (SOC_TX_VALID && SOC_TX_READY)
        soc_hold <= SOC_TX_BYTE;
    end
  end

  // contact inputs come from pins: two-stage synchroniser
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ct_s1 <= 2'h0;
      ct_s2 <= 2'h0;
    end
    else if (CLK_EN)
    begin
      ct_s1 <= CONTACT_IN;
      ct_s2 <= ct_s1;
    end
  end

  // ****************************************
  // receive deframer
  // ****************************************
  ofm_lock_t lk;
  ofm_lock_t next_lk;
  logic [1:0] rx_fb;
  logic [7:0] rx_dcnt;
  logic [7:0] rx_load;
  logic [1:0] miss;
  logic [1:0] next_miss;
  logic next_lost;
  logic rx_on;
  logic rx_ext;
  logic rx_fr;
  logic faw_hit;
  logic rx_lk;
  logic [14:0] rx_lfsr;
  logic [7:0] rx_data;

  assign rx_on = ctrl.rx_mode != MODE_OFF;
  assign rx_ext = (ctrl.rx_mode == MODE_ENH) || (ctrl.rx_mode == MODE_CUST);
  assign rx_load = (ctrl.rx_mode == MODE_CUST) ?
    ((ctrl.rx_load < LOAD_MIN) ? LOAD_MIN : ctrl.rx_load) : LOAD_FIXED;
  assign rx_fr = rx_on && lk != LK_HUNT && rx_dcnt == 8'h00;
  assign faw_hit = AGG_RX_BYTE[6:0] == FAW;
  assign rx_lk = lk == LK_LOCKED;
  assign rx_data = AGG_RX_BYTE ^ ((ctrl.scram_en && rx_on) ? rx_lfsr[7:0] : 8'h00);

  // lock: one hit to verify, second hit to lock, third straight miss loses it
  always_comb
  begin
    next_lk = lk;
    next_miss = miss;
    next_lost = 1'b0;
    if (!rx_on)
      next_lk = LK_HUNT;
    else if (AGG_RX_VALID)
    begin
      case (lk)
        LK_HUNT:
          if (faw_hit)
            next_lk = LK_VERIFY;
        LK_VERIFY:
          if (rx_fr && rx_fb == FB_ALIGN)
          begin
            next_lk = faw_hit ? LK_LOCKED : LK_HUNT;
            next_miss = 2'h0;
          end
        LK_LOCKED:
          if (rx_fr && rx_fb == FB_ALIGN)
          begin
            if (faw_hit)
              next_miss = 2'h0;
            else if (miss == MISS_LIMIT)
            begin
              next_lk = LK_HUNT; // see RULE_24
              next_lost = 1'b1;
              next_miss = 2'h0;
            end
            else
              next_miss = miss + 2'h1;
          end
        default: next_lk = LK_HUNT;
      endcase
    end
  end

  // lock state and receive position counters
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      lk <= LK_HUNT;
      miss <= 2'h0;
      LOCKED <= 1'b0;
      LOCK_LOST <= 1'b0;
      rx_fb <= FB_ALIGN;
      rx_dcnt <= 8'h00;
    end
    else if (CLK_EN)
    begin
      lk <= next_lk;
      miss <= next_miss;
      LOCKED <= next_lk == LK_LOCKED;
      LOCK_LOST <= next_lost;
      if (AGG_RX_VALID)
      begin
        if (lk == LK_HUNT)
        begin
          rx_fb <= FB_ALIGN;
          rx_dcnt <= 8'h01;
        end
        else if (rx_dcnt >= rx_load)
        begin
          rx_dcnt <= 8'h00;
          rx_fb <= rx_fb + 2'h1;
        end
        else
          rx_dcnt <= rx_dcnt + 8'h01;
      end
    end
  end

  // descrambler mirrors the transmit one
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
      rx_lfsr <= LFSR_SEED;
    else if (CLK_EN && AGG_RX_VALID)
    begin
      if ((lk == LK_HUNT && faw_hit) || (rx_fr && rx_fb == FB_ALIGN))
        rx_lfsr <= LFSR_SEED; // see RULE_21
      else if (!rx_fr)
        rx_lfsr <= {rx_lfsr[13:0], rx_lfsr[14] ^ rx_lfsr[13]};
    end
  end

  // channel extraction; nothing leaves until the frame is locked, except through data passed raw while rx mode is off
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      TD_RX_BYTE <= 8'h00;
      TD_RX_VALID <= 1'b0;
      SOC_RX_BYTE <= 8'h00;
      SOC_RX_VALID <= 1'b0;
      SOC_RX_BIT <= 1'b0;
      SOC_RX_CLK <= 1'b0;
      RELAY_OUT <= 2'h0;
      rx_ovh <= OVH_RST;
    end
    else if (CLK_EN)
    begin
      TD_RX_VALID <= AGG_RX_VALID && (!rx_on || (rx_lk && !rx_fr)); // see RULE_04
      SOC_RX_VALID <= 1'b0;
      SOC_RX_CLK <= 1'b0;
      if (AGG_RX_VALID && (!rx_on || !rx_fr))
        TD_RX_BYTE <= rx_data;
      if (AGG_RX_VALID && rx_lk && rx_fr)
      begin
        case (rx_fb)
          FB_ALIGN:
            if (rx_ext)
              rx_ovh.ucc[0] <= AGG_RX_BYTE[B1]; // see RULE_16
          FB_SIG_A, FB_SIG_B:
            if (rx_ext && AGG_RX_BYTE != SOC_IDLE)
            begin
              SOC_RX_BYTE <= AGG_RX_BYTE; // see RULE_15
              SOC_RX_VALID <= 1'b1;
            end
          default:
          begin
            rx_ovh.bwd_alarm <= AGG_RX_BYTE[B3]; // see RULE_08
            rx_ovh.mframe <= AGG_RX_BYTE[B4]; // see RULE_09
            if (rx_ext)
            begin
              rx_ovh.ucc[1] <= AGG_RX_BYTE[B1];
              rx_ovh.ucc[2] <= AGG_RX_BYTE[B5];
              rx_ovh.ucc[3] <= AGG_RX_BYTE[B6];
              if (ctrl.rx_mode == MODE_CUST)
                RELAY_OUT <= {AGG_RX_BYTE[B8], AGG_RX_BYTE[B7]}; // see RULE_20
              else
                rx_ovh.ucc[5:4] <= {AGG_RX_BYTE[B8], AGG_RX_BYTE[B7]};
            end
            else
            begin
              SOC_RX_BIT <= AGG_RX_BYTE[B1]; // see RULE_06 see RULE_12
              SOC_RX_CLK <= ctrl.iface_se; // see RULE_13 see RULE_14
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  sequence s_tx_slot(logic [1:0] pos);
    CLK_EN && AGG_TX_REQ && tx_fr && tx_fb == pos;
  endsequence

  chk_frame_align_word: assert property (s_tx_slot(FB_ALIGN) |=> AGG_TX_BYTE[6:0] == FAW) // see RULE_07
    else $error("alignment word missing at frame start");
  chk_house_align_bit: assert property (s_tx_slot(FB_HOUSE) |=> AGG_TX_BYTE[B2] == BIT32_ALIGN) // see RULE_07
    else $error("byte 32 alignment bit wrong");
  chk_std_sig_empty: assert property ((s_tx_slot(FB_SIG_A) and ctrl.tx_mode == MODE_STD)
    |=> AGG_TX_BYTE == 8'h00) // see RULE_05
    else $error("signalling byte not empty in standard mode");
  chk_std_spare_bits: assert property ((s_tx_slot(FB_HOUSE) and ctrl.tx_mode == MODE_STD)
    |=> AGG_TX_BYTE[3:0] == 4'h0) // see RULE_10
    else $error("unused byte 32 bits driven in standard mode");
  chk_fixed_segment: assert property ((ctrl.tx_mode == MODE_STD || ctrl.tx_mode == MODE_ENH)
    && CLK_EN && AGG_TX_REQ && tx_dcnt == LOAD_FIXED |=> tx_dcnt == 8'h00) // see RULE_23 see RULE_11
    else $error("fixed-mode segment is not 16 bytes");
  chk_td_take: assert property (CLK_EN && AGG_TX_REQ && !tx_fr && TD_TX_VALID
    |=> TD_TX_TAKE && AGG_TX_VALID) // see RULE_04
    else $error("data byte sent without take strobe");
  chk_clk_diff_off: assert property (!ctrl.iface_se && !$past(ctrl.iface_se)
    |-> !SOC_TX_CLK && !SOC_RX_CLK) // see RULE_14
    else $error("service clock on differential interface");
  chk_lock_loss_flag: assert property (LOCK_LOST |-> !LOCKED ##1 !LOCK_LOST) // see RULE_24
    else $error("loss flag not a pulse with lock dropped");
  chk_no_data_unlocked: assert property (rx_on && $past(rx_on) && !LOCKED && !$past(LOCKED)
    && !$past(rx_lk) |-> !TD_RX_VALID) // see RULE_24
    else $error("data passed before frame lock");

endmodule // ofm_framer
`default_nettype wire

// ==== dv/ofm_far_end.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far-end modem: modulator pull, link loopback, terrestrial source
// ****************************************
module ofm_far_end
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  // aggregate side
  output logic agg_req,
  input wire logic [7:0] agg_tx_byte,
  input wire logic agg_tx_valid,
  output logic [7:0] agg_rx_byte,
  output logic agg_rx_valid,
  // terrestrial source
  output logic [7:0] td_byte,
  output logic td_valid,
  input wire logic td_take
);
  // every other cycle, since the source only sees each take one cycle late
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) agg_req <= 1'b0;
    else agg_req <= run && !agg_req;
  end
  // loopback keeps both directions in one mode; idle line toggles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) agg_rx_valid <= 1'b0;
    else agg_rx_valid <= agg_tx_valid;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) agg_rx_byte <= 8'h00;
    else agg_rx_byte <= agg_tx_valid ? agg_tx_byte : ~agg_rx_byte;
  end
  // counting source, advances on each take
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) td_byte <= 8'h00;
    else if (td_take) td_byte <= td_byte + 8'h01;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) td_valid <= 1'b0;
    else td_valid <= run;
  end
endmodule // ofm_far_end
`default_nettype wire

// ==== dv/overhead_frame_multiplexer_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module overhead_frame_multiplexer_tb_top;
  import ofm_pkg::*;
  typedef struct packed {logic [7:0] idx; logic [7:0] mask; logic [7:0] val;} ofm_row_t;
  // ****************************************
  // signals
  // ****************************************
  logic SYS_CLK = 1'b0;
  logic RESETN = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [7:0] SOC_TX_BYTE = 8'h00;
  logic SOC_TX_VALID = 1'b0;
  logic SOC_TX_BIT = 1'b0;
  logic [1:0] CONTACT_IN = 2'h0;
  logic run = 1'b0;
  wire logic [31:0] HRDATA;
  wire logic HREADYOUT, HRESP, TD_TX_TAKE, AGG_TX_REQ, AGG_TX_VALID, AGG_RX_VALID;
  wire logic [7:0] TD_TX_BYTE, AGG_TX_BYTE, AGG_RX_BYTE, TD_RX_BYTE, SOC_RX_BYTE;
  wire logic TD_TX_VALID, TD_RX_VALID, SOC_TX_READY, SOC_TX_CLK, SOC_RX_VALID;
  wire logic SOC_RX_BIT, SOC_RX_CLK, LOCKED, LOCK_LOST;
  wire logic [1:0] RELAY_OUT;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int n = 0;
  int takes = 0;
  int i, tc, rc;
  logic [7:0] cap [128];
  logic [31:0] rd;
  // frame positions of standard mode with alarm and service bit set
  ofm_row_t rows [4] = '{'{8'd0, 8'h7F, 8'h1B}, '{8'd32, 8'hF0, 8'hE0},
                         '{8'd64, 8'h7F, 8'h1B}, '{8'd96, 8'hF0, 8'hE0}};
  // ****************************************
  // instances
  // ****************************************
  ofm_framer ofm_framer_inst (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CLK_EN(1'b1),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .TD_TX_BYTE(TD_TX_BYTE), .TD_TX_VALID(TD_TX_VALID),
    .TD_TX_TAKE(TD_TX_TAKE), .AGG_TX_REQ(AGG_TX_REQ), .AGG_TX_BYTE(AGG_TX_BYTE),
    .AGG_TX_VALID(AGG_TX_VALID), .AGG_RX_BYTE(AGG_RX_BYTE), .AGG_RX_VALID(AGG_RX_VALID),
    .TD_RX_BYTE(TD_RX_BYTE), .TD_RX_VALID(TD_RX_VALID), .SOC_TX_BYTE(SOC_TX_BYTE),
    .SOC_TX_VALID(SOC_TX_VALID), .SOC_TX_READY(SOC_TX_READY), .SOC_TX_BIT(SOC_TX_BIT),
    .SOC_TX_CLK(SOC_TX_CLK), .SOC_RX_BYTE(SOC_RX_BYTE), .SOC_RX_VALID(SOC_RX_VALID),
    .SOC_RX_BIT(SOC_RX_BIT), .SOC_RX_CLK(SOC_RX_CLK), .CONTACT_IN(CONTACT_IN),
    .RELAY_OUT(RELAY_OUT), .LOCKED(LOCKED), .LOCK_LOST(LOCK_LOST));
  ofm_far_end ofm_far_end_inst (.clk(SYS_CLK), .rst_n(RESETN), .run(run),
    .agg_req(AGG_TX_REQ), .agg_tx_byte(AGG_TX_BYTE), .agg_tx_valid(AGG_TX_VALID),
    .agg_rx_byte(AGG_RX_BYTE), .agg_rx_valid(AGG_RX_VALID), .td_byte(TD_TX_BYTE),
    .td_valid(TD_TX_VALID), .td_take(TD_TX_TAKE));
  // ****************************************
  // clock, capture, timeout
  // ****************************************
  initial
  begin
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  // first two frames after start, with the data takes seen meanwhile
  always @(posedge SYS_CLK)
  begin
    if (run && n < 128)
    begin
      takes <= takes + int'(TD_TX_TAKE === 1'b1);
      if (AGG_TX_VALID === 1'b1)
      begin
        cap[n] <= AGG_TX_BYTE;
        n <= n + 1;
      end
    end
  end
  // whole run needs well under this; a hang counts as a mismatch
  initial
  begin
    while (cyc < 60000)
    begin
      @(posedge SYS_CLK);
      cyc++;
    end
    err_count++;
    close_out();
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge SYS_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= wr;
    HADDR <= {24'h000000, a};
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
    rd = HRDATA;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // counts service clock pulses over exactly two standard frames
  task automatic clk_window();
    tc = 0;
    rc = 0;
    repeat (256)
    begin
      @(posedge SYS_CLK);
      tc += int'(SOC_TX_CLK === 1'b1);
      rc += int'(SOC_RX_CLK === 1'b1);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    chk(32'(HREADYOUT), 32'h1);
    chk(32'(HRESP), 32'h0);
    ahb(1'b1, OFF_CTRL, 32'h00000015);
    ahb(1'b1, OFF_TX_OVH, 32'h00000001);
    SOC_TX_BIT <= 1'b1;
    ahb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, 32'h00000015);
    run <= 1'b1;
    for (i = 0; i < 2000 && n < 128; i++) @(posedge SYS_CLK);
    foreach (rows[r]) chk(32'(cap[rows[r].idx] & rows[r].mask), 32'(rows[r].val));
    chk(32'(takes), 32'd120);
    for (i = 0; i < 3000 && LOCKED !== 1'b1; i++) @(posedge SYS_CLK);
    chk(32'(LOCKED), 32'h1);
    ahb(1'b0, OFF_RX_OVH, 32'h0);
    chk(rd & 32'h00000103, 32'h00000101);
    clk_window();
    chk(32'(SOC_RX_BIT), 32'h1);
    chk(32'(tc + rc), 32'd4);
    ahb(1'b1, OFF_CTRL, 32'h00000005);
    // a pulse launched at the write edge still used the old interface
    @(posedge SYS_CLK);
    clk_window();
    chk(32'(tc + rc), 32'd0);
    // enhanced: one service byte across the loop
    ahb(1'b1, OFF_CTRL, 32'h0000001F);
    // let standard-mode bytes still in the loop drain past the new rx mode
    repeat (2) @(posedge SYS_CLK);
    for (i = 0; i < 2000 && SOC_TX_READY !== 1'b1; i++) @(posedge SYS_CLK);
    SOC_TX_BYTE <= 8'h5A;
    SOC_TX_VALID <= 1'b1;
    @(posedge SYS_CLK);
    while (SOC_TX_READY !== 1'b1) @(posedge SYS_CLK);
    SOC_TX_VALID <= 1'b0;
    for (i = 0; i < 3000 && SOC_RX_VALID !== 1'b1; i++) @(posedge SYS_CLK);
    chk(32'(SOC_RX_BYTE), 32'h5A);
    // control channel bits across the loop, two frames to settle
    ahb(1'b1, OFF_TX_OVH, 32'h000000FD);
    repeat (300) @(posedge SYS_CLK);
    ahb(1'b0, OFF_RX_OVH, 32'h0);
    chk(rd & 32'h000000FF, 32'h000000FD);
    // transmit off while receive still expects frames
    ahb(1'b1, OFF_CTRL, 32'h0000000C);
    for (i = 0; i < 3000 && LOCK_LOST !== 1'b1; i++) @(posedge SYS_CLK);
    chk(32'(LOCK_LOST), 32'h1);
    ahb(1'b0, OFF_RX_OVH, 32'h0);
    chk(rd & 32'h00000300, 32'h00000200);
    ahb(1'b1, OFF_RX_OVH, 32'h00000200);
    ahb(1'b0, OFF_RX_OVH, 32'h0);
    chk(rd & 32'h00000200, 32'h0);
    // custom, shortest load, contacts carried to relays
    CONTACT_IN <= 2'h2;
    ahb(1'b1, OFF_CTRL, 32'h0000407A);
    for (i = 0; i < 3000 && RELAY_OUT !== 2'h2; i++) @(posedge SYS_CLK);
    chk(32'(LOCKED), 32'h1);
    chk(32'(RELAY_OUT), 32'h2);
    // scrambled through data comes back in source order
    while (TD_RX_VALID !== 1'b1) @(posedge SYS_CLK);
    rd = 32'(TD_RX_BYTE);
    @(posedge SYS_CLK);
    while (TD_RX_VALID !== 1'b1) @(posedge SYS_CLK);
    chk(32'(TD_RX_BYTE), 32'(rd[7:0] + 8'h01));
    // reset in mid-run drops lock and relays at once
    RESETN <= 1'b0;
    @(posedge SYS_CLK);
    chk(32'({LOCKED, RELAY_OUT, HREADYOUT}), 32'h1);
    close_out();
  end
endmodule // overhead_frame_multiplexer_tb_top
`default_nettype wire
